/* File: dma_fault_map.svh */
`ifndef DMA_FAULT_MAP_SVH
`define DMA_FAULT_MAP_SVH

// channel count and channel number width
`define DMA_NUM_PER_CHANNEL_BITS       27
`define DMA_PER_CHANNEL_BITS_ID_W      5

// register byte offsets on the wishbone port
`define REG_BUS_FLAGS_OFS  8'h00
`define REG_COMB_FLAGS_OFS 8'h04
`define REG_IRQ_MASK_OFS   8'h08
`define REG_EN_SET_OFS     8'h0c
`define REG_EN_CLR_OFS     8'h10
`define REG_LAST_FAULT_OFS 8'h14
`define REG_FAULT_CNT_OFS  8'h18

// reset values
`define REG_FLAGS_RST      27'h0000000
`define REG_MASK_RST       27'h0000000
`define REG_EN_RST         27'h0000000
`define REG_CNT_RST        16'h0000

// last fault register layout
`define LAST_PER_CHANNEL_BITS_LSB      0
`define LAST_CAUSE_LSB     8
`define LAST_VALID_BIT     15

// descriptor cycle control value that marks a bad descriptor
`define CC_INVALID         3'h0

// saturating fault counter width
`define FAULT_CNT_W        16

`endif

/* File: dma_fault_pkg.sv */
package dma_fault_pkg;
  `include "dma_fault_map.svh"

  typedef logic [`DMA_NUM_PER_CHANNEL_BITS-1:0]  per_channel_bits_vec_t;
  typedef logic [`DMA_PER_CHANNEL_BITS_ID_W-1:0] per_channel_bits_id_t;
  typedef logic [2:0]                cyc_ctrl_t;

  // cause of the most recent fault
  typedef enum logic [1:0] {
    CAUSE_NONE,
    CAUSE_BUS,
    CAUSE_DESC
  } cause_t;

  // wishbone slave handshake state
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

  // one-hot channel vector; numbers past the last channel are dropped
  function automatic per_channel_bits_vec_t per_channel_bits_onehot(input logic hit, input per_channel_bits_id_t id);
    per_channel_bits_vec_t v;
    v = '0;
    if (hit && (32'(id) < `DMA_NUM_PER_CHANNEL_BITS)) begin
      v[id] = 1'b1;
    end
    return v;
  endfunction

  // write data gated by the byte lanes that are selected
  function automatic logic [31:0] lane_mask(input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = dat[i*8 +: 8] & {8{sel[i]}};
    end
    return m;
  endfunction
endpackage

/* File: flag_ctl_if.sv */
`timescale 1ns/1ps
interface flag_ctl_if #(parameter int W = 27);
  logic [W-1:0] set_v;
  logic [W-1:0] clr_v;
  logic [W-1:0] flags;

  modport ctrl (output set_v, output clr_v, input flags);
  modport bank (input set_v, input clr_v, output flags);
endinterface

/* File: fault_flag_bank.sv */
`timescale 1ns/1ps
`include "dma_fault_map.svh"
module fault_flag_bank #(
  parameter int WIDTH = `DMA_NUM_PER_CHANNEL_BITS
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  flag_ctl_if.bank   ctl
);
  // sticky flags: a set in the same cycle as its clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl.flags <= WIDTH'(`REG_FLAGS_RST);
    end else begin
      ctl.flags <= (ctl.flags & ~ctl.clr_v) | ctl.set_v;
    end
  end
endmodule

/* File: per_channel_bits_enable_bank.sv */
`timescale 1ns/1ps
`include "dma_fault_map.svh"
module per_channel_bits_enable_bank #(
  parameter int WIDTH = `DMA_NUM_PER_CHANNEL_BITS
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  flag_ctl_if.bank   ctl
);
  // enables: disable wins, so a faulting channel never stays on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl.flags <= WIDTH'(`REG_EN_RST);
    end else begin
      ctl.flags <= (ctl.flags | ctl.set_v) & ~ctl.clr_v;
    end
  end
endmodule

/* File: dma_error_status_clear.sv */
// Functional notes
// R1 - bus fault flag field spans bits 26:0, one flag per channel.
// R2 - bit 0 is channel 0; each bit number equals its channel.
// R3 - bus error response during a channel's transfer sets its bus fault flag.
// R4 - bus error disables only the faulting channel; others keep running.
// R5 - bus fault read: 1 means pending error, 0 means none.
// R6 - writing 1 clears a bus fault flag; writing 0 leaves it.
// R7 - combined field bits 26:0 set on bus error or cycle control 000.
// R8 - invalid descriptor disables only that channel; others keep running.
// R9 - combined read: 1 pending bus error or bad descriptor, else 0.
// R10 - writing 1 clears a combined flag; writing 0 leaves it.
// R11 - new event in the clearing cycle keeps the flag set.
`timescale 1ns/1ps
`include "dma_fault_map.svh"
module dma_error_status_clear (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone classic slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // bus error seen on a transfer
  input  wire logic                   xfer_err_i,
  input  wire dma_fault_pkg::per_channel_bits_id_t xfer_err_per_channel_bits_i,
  // descriptor fetched
  input  wire logic                   desc_fetch_i,
  input  wire dma_fault_pkg::per_channel_bits_id_t desc_per_channel_bits_i,
  input  wire dma_fault_pkg::cyc_ctrl_t desc_cc_i,
  // channel enables and interrupt
  output dma_fault_pkg::per_channel_bits_vec_t    per_channel_bits_en_o,
  output logic                        irq_o
);
  import dma_fault_pkg::*;

  localparam int NCH = `DMA_NUM_PER_CHANNEL_BITS;

  // word index compare; offsets are byte addresses, so lanes drop out
  function automatic logic hit_word(input logic [5:0] idx, input logic [7:0] ofs);
    return idx == ofs[7:2];
  endfunction

  // channel vector widened to a bus word; unused high bits read zero
  function automatic logic [31:0] pad_word(input logic [NCH-1:0] v);
    return {{(32-NCH){1'b0}}, v};
  endfunction

  // carriers between this module and the flag banks
  flag_ctl_if #(.W(NCH)) bus_if  ();
  flag_ctl_if #(.W(NCH)) comb_if ();
  flag_ctl_if #(.W(NCH)) en_if   ();

  bus_state_t           bus_state;
  bus_state_t           next_bus_state;
  per_channel_bits_vec_t            irq_mask;
  logic [`FAULT_CNT_W-1:0] fault_cnt;
  per_channel_bits_id_t             last_per_channel_bits;
  cause_t               last_cause;
  logic                 last_valid;

  // bus request decode
  wire logic        bus_req;
  wire logic        bus_wr;
  wire logic        bus_rd;
  wire logic [31:0] wr_bits;
  wire logic [5:0]  word_idx;

  assign bus_req  = wb_cyc_i & wb_stb_i & (bus_state == BUS_IDLE);
  assign bus_wr   = bus_req & wb_we_i;
  assign bus_rd   = bus_req & ~wb_we_i;
  assign wr_bits  = lane_mask(wb_dat_i, wb_sel_i);
  assign word_idx = wb_adr_i[7:2];

  // register hits, compared on the word index only
  wire logic hit_bus;
  wire logic hit_comb;
  wire logic hit_mask;
  wire logic hit_en_set;
  wire logic hit_en_clr;
  wire logic hit_last;
  wire logic hit_cnt;

  assign hit_bus    = hit_word(word_idx, `REG_BUS_FLAGS_OFS);
  assign hit_comb   = hit_word(word_idx, `REG_COMB_FLAGS_OFS);
  assign hit_mask   = hit_word(word_idx, `REG_IRQ_MASK_OFS);
  assign hit_en_set = hit_word(word_idx, `REG_EN_SET_OFS);
  assign hit_en_clr = hit_word(word_idx, `REG_EN_CLR_OFS);
  assign hit_last   = hit_word(word_idx, `REG_LAST_FAULT_OFS);
  assign hit_cnt    = hit_word(word_idx, `REG_FAULT_CNT_OFS);

  // write strobes per register; the channel vectors are gated by byte lanes, wr_mask and wr_last are not
  wire per_channel_bits_vec_t w1c_bus;
  wire per_channel_bits_vec_t w1c_comb;
  wire per_channel_bits_vec_t w1s_en;
  wire per_channel_bits_vec_t w1c_en;
  wire logic      wr_mask;
  wire logic      wr_last;

  // R6 write one clears
  assign w1c_bus  = (bus_wr && hit_bus) ? wr_bits[NCH-1:0] : '0;
  // R10 write one clears
  assign w1c_comb = (bus_wr && hit_comb) ? wr_bits[NCH-1:0] : '0;
  assign w1s_en   = (bus_wr && hit_en_set) ? wr_bits[NCH-1:0] : '0;
  assign w1c_en   = (bus_wr && hit_en_clr) ? wr_bits[NCH-1:0] : '0;
  assign wr_mask  = bus_wr & hit_mask;
  assign wr_last  = bus_wr & hit_last;

  // fault events, one-hot per channel
  wire logic      desc_bad;
  wire per_channel_bits_vec_t bus_evt;
  wire per_channel_bits_vec_t desc_evt;
  wire per_channel_bits_vec_t any_evt;

  // R2 channel number picks the bit
  // R3 bus error sets its channel
  assign bus_evt  = per_channel_bits_onehot(xfer_err_i, xfer_err_per_channel_bits_i);
  // R7 cycle control zero is invalid
  assign desc_bad = desc_fetch_i & (desc_cc_i == `CC_INVALID);
  assign desc_evt = per_channel_bits_onehot(desc_bad, desc_per_channel_bits_i);
  assign any_evt  = bus_evt | desc_evt;

  // bus fault flags see only bus errors
  // R1 one bit per channel
  // R11 set beats clear in bank
  assign bus_if.set_v  = bus_evt;
  assign bus_if.clr_v  = w1c_bus;

  // combined flags see both kinds of fault
  // R7 set on either cause
  assign comb_if.set_v = any_evt;
  assign comb_if.clr_v = w1c_comb;

  // enables: software set, software clear, fault disable
  // R4 disable the bus fault channel only
  // R8 disable the bad descriptor channel only
  assign en_if.set_v   = w1s_en;
  assign en_if.clr_v   = w1c_en | any_evt;

  fault_flag_bank #(
    .WIDTH (NCH)
  ) u_bus_flags (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl   (bus_if.bank)
  );

  fault_flag_bank #(
    .WIDTH (NCH)
  ) u_comb_flags (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl   (comb_if.bank)
  );

  per_channel_bits_enable_bank #(
    .WIDTH (NCH)
  ) u_per_channel_bits_en (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl   (en_if.bank)
  );

  // enables leave straight from the bank flops
  assign per_channel_bits_en_o = en_if.flags;

  // last fault capture; a bus error outranks a descriptor fault
  wire logic     evt_seen;
  wire per_channel_bits_id_t next_last_per_channel_bits;
  wire cause_t   next_last_cause;

  assign evt_seen        = |any_evt;
  assign next_last_per_channel_bits  = (|bus_evt) ? xfer_err_per_channel_bits_i : desc_per_channel_bits_i;
  assign next_last_cause = (|bus_evt) ? CAUSE_BUS : CAUSE_DESC;

  // fault counter saturates so software never sees a wrap
  wire logic                    cnt_full;
  wire logic [`FAULT_CNT_W-1:0] cnt_step;
  wire logic                    wr_cnt;
  wire logic [`FAULT_CNT_W-1:0] cnt_sum;

  assign cnt_full = &fault_cnt;
  assign cnt_step = {{(`FAULT_CNT_W-2){1'b0}}, (|bus_evt) & (|desc_evt), 1'b0}
                  | {{(`FAULT_CNT_W-1){1'b0}}, (|bus_evt) ^ (|desc_evt)};
  assign wr_cnt   = bus_wr & hit_cnt;
  // clamp at all ones instead of wrapping
  assign cnt_sum  = (fault_cnt >= ~cnt_step) ? {`FAULT_CNT_W{1'b1}} : fault_cnt + cnt_step;

  // unmasked combined flags drive the interrupt
  wire logic irq_next;

  assign irq_next = |(comb_if.flags & irq_mask);

  // read data mux; unmapped words read zero
  wire logic [31:0] rd_data;
  wire logic [31:0] last_word;

  assign last_word = {16'h0000,
                      last_valid,
                      5'h00,
                      last_cause,
                      3'h0,
                      last_per_channel_bits};

  // R5 bus fault read back
  // R9 combined read back
  assign rd_data = hit_bus    ? pad_word(bus_if.flags)  :
                   hit_comb   ? pad_word(comb_if.flags) :
                   hit_mask   ? pad_word(irq_mask)      :
                   hit_en_set ? pad_word(en_if.flags)   :
                   hit_en_clr ? pad_word(en_if.flags)   :
                   hit_last   ? last_word                          :
                   hit_cnt    ? {16'h0000, fault_cnt}             :
                   32'h00000000;

  // handshake: one ack per request, then one idle cycle
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (bus_req) begin
          next_bus_state = BUS_ACK;
        end
      end
      BUS_ACK: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  // state and ack flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= BUS_IDLE;
      wb_ack_o  <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      wb_ack_o  <= bus_req;
    end
  end

  // read data held from ack until the next read request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_rd) begin
      wb_dat_o <= rd_data;
    end
  end

  // interrupt mask, plain read/write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= `REG_MASK_RST;
    end else if (wr_mask) begin
      irq_mask <= wr_bits[NCH-1:0];
    end
  end

  // level interrupt from combined flags; one cycle behind them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_next;
    end
  end

  // last fault record; a write to it empties it unless a fault lands in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_per_channel_bits  <= '0;
      last_cause <= CAUSE_NONE;
      last_valid <= 1'b0;
    end else if (evt_seen) begin
      last_per_channel_bits  <= next_last_per_channel_bits;
      last_cause <= next_last_cause;
      last_valid <= 1'b1;
    end else if (wr_last) begin
      last_per_channel_bits  <= '0;
      last_cause <= CAUSE_NONE;
      last_valid <= 1'b0;
    end
  end

  // counter; a write resets it, a fault in that cycle still counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_cnt <= `REG_CNT_RST;
    end else if (wr_cnt) begin
      fault_cnt <= cnt_step;
    end else if (!cnt_full && evt_seen) begin
      fault_cnt <= cnt_sum;
    end
  end

endmodule

/* File: dma_error_status_clear_chk.sv */
`timescale 1ns/1ps
`include "dma_fault_map.svh"
module dma_error_status_clear_chk
  import dma_fault_pkg::*;
(
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [7:0]                wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic                      xfer_err_i,
  input wire dma_fault_pkg::per_channel_bits_id_t   xfer_err_per_channel_bits_i,
  input wire logic                      desc_fetch_i,
  input wire dma_fault_pkg::per_channel_bits_id_t   desc_per_channel_bits_i,
  input wire dma_fault_pkg::cyc_ctrl_t  desc_cc_i,
  input wire dma_fault_pkg::per_channel_bits_vec_t  per_channel_bits_en_o,
  input wire logic                      irq_o
);
  // request decode shared by the properties
  wire logic req   = wb_cyc_i && wb_stb_i;
  wire logic wr    = req && wb_we_i;
  wire logic quiet = !xfer_err_i && !desc_fetch_i && !wr;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_needs_req: assert property (!req |=> !wb_ack_o) else $error("ack unasked");
  a_read_hold: assert property (!(req && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved");
  a_bus_disable: assert property (xfer_err_i && xfer_err_per_channel_bits_i < 27
    |=> !per_channel_bits_en_o[$past(xfer_err_per_channel_bits_i)]) else $error("faulted channel still on");
  a_desc_disable: assert property (desc_fetch_i && desc_cc_i == `CC_INVALID
    && desc_per_channel_bits_i < 27 |=> !per_channel_bits_en_o[$past(desc_per_channel_bits_i)]) else $error("bad desc on");
  a_others_run: assert property (xfer_err_i && !desc_fetch_i && !wr
    |=> ((per_channel_bits_en_o ^ $past(per_channel_bits_en_o)) & ~(per_channel_bits_vec_t'(1) << $past(xfer_err_per_channel_bits_i))) == '0)
    else $error("other channel touched");
  a_good_desc: assert property (desc_fetch_i && desc_cc_i != `CC_INVALID && !xfer_err_i
    && !wr |=> $stable(per_channel_bits_en_o)) else $error("good desc disabled");
  a_en_by_write: assert property ((per_channel_bits_en_o & ~$past(per_channel_bits_en_o)) != '0
    |-> $past(wr && wb_adr_i[7:2] == 6'h03)) else $error("enable without write");
  a_irq_quiet: assert property ((quiet && !irq_o)[*2] |=> !irq_o)
    else $error("irq without cause");

  c_clear_race: cover property (xfer_err_i && wr);
  c_irq_rise: cover property ($rose(irq_o));
  c_bad_desc: cover property (desc_fetch_i && desc_cc_i == `CC_INVALID);
endmodule

bind dma_error_status_clear dma_error_status_clear_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .xfer_err_i(xfer_err_i), .xfer_err_per_channel_bits_i(xfer_err_per_channel_bits_i), .desc_fetch_i(desc_fetch_i),
  .desc_per_channel_bits_i(desc_per_channel_bits_i), .desc_cc_i(desc_cc_i), .per_channel_bits_en_o(per_channel_bits_en_o), .irq_o(irq_o));

/* File: bus_slave_model.sv */
`timescale 1ns/1ps
module bus_slave_model
  import dma_fault_pkg::*;
(
  input  wire logic                 clk_i,
  output logic                      err_o,
  output dma_fault_pkg::per_channel_bits_id_t   err_per_channel_bits_o,
  output logic                      fetch_o,
  output dma_fault_pkg::per_channel_bits_id_t   fetch_per_channel_bits_o,
  output dma_fault_pkg::cyc_ctrl_t  fetch_cc_o
);
  // quiet lines at time zero
  initial begin
    err_o        = 1'b0;
    err_per_channel_bits_o   = 5'h1f;
    fetch_o      = 1'b0;
    fetch_per_channel_bits_o = 5'h1f;
    fetch_cc_o   = 3'h7;
  end

  task automatic fault(input per_channel_bits_id_t ch);
    @(posedge clk_i);
    err_o      <= 1'b1;
    err_per_channel_bits_o <= ch;
    @(posedge clk_i);
    err_o      <= 1'b0;
    err_per_channel_bits_o <= ~ch; // stale id inverted so it differs from the one just driven
  endtask

  task automatic fetch(input per_channel_bits_id_t ch, input cyc_ctrl_t cc);
    @(posedge clk_i);
    fetch_o      <= 1'b1;
    fetch_per_channel_bits_o <= ch;
    fetch_cc_o   <= cc;
    @(posedge clk_i);
    fetch_o      <= 1'b0;
    fetch_per_channel_bits_o <= ~ch;
    fetch_cc_o   <= ~cc;
  endtask
endmodule

/* File: dma_error_status_clear_tb.sv */
`timescale 1ns/1ps
module dma_error_status_clear_tb;
  import dma_fault_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq, err, fch;
  logic [7:0]  adr;
  logic [3:0]  sel, lanes;
  logic [31:0] dat, q_o, bf, cf, en;
  per_channel_bits_id_t    err_ch, fch_ch;
  cyc_ctrl_t   fch_cc;
  per_channel_bits_vec_t   per_channel_bits_en;
  int          num_errors, num_checks;
  int          chs[3] = '{0, 13, 26};

  dma_error_status_clear u_dma_error_status_clear (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(q_o), .wb_ack_o(ack), .xfer_err_i(err), .xfer_err_per_channel_bits_i(err_ch),
    .desc_fetch_i(fch), .desc_per_channel_bits_i(fch_ch), .desc_cc_i(fch_cc), .per_channel_bits_en_o(per_channel_bits_en),
    .irq_o(irq));
  bus_slave_model u_bus_slave_model (.clk_i(clk_i), .err_o(err), .err_per_channel_bits_o(err_ch),
    .fetch_o(fch), .fetch_per_channel_bits_o(fch_ch), .fetch_cc_o(fch_cc));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle; bounded wait on ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, lanes};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = q_o;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  // irq is a registered level, so look a cycle later
  task automatic irq_is(input logic exp);
    @(posedge clk_i);
    #1 chk({31'h0, irq}, {31'h0, exp});
  endtask

  initial begin
    {rst_i, cyc, stb, we, adr, dat} = {1'b1, 43'h0};
    {sel, lanes} = 8'hff;
    num_errors = 0;
    num_checks = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h0c, 32'h0);
    $display("test reset done");
    wr(8'h0c, 32'h07ff_ffff);
    {bf, cf, en} = {32'h0, 32'h0, 32'h07ff_ffff};
    foreach (chs[i]) begin
      u_bus_slave_model.fault(5'(chs[i]));
      bf[chs[i]] = 1'b1;
      en[chs[i]] = 1'b0;
      rd(8'h00, bf);
      rd(8'h04, bf);
      rd(8'h0c, en);
      chk({5'h0, per_channel_bits_en}, en);
    end
    cf = bf;
    $display("test bus fault done");
    u_bus_slave_model.fetch(5'd5, 3'h0);
    cf[5] = 1'b1;
    en[5] = 1'b0;
    for (int c = 1; c < 8; c++) u_bus_slave_model.fetch(5'd6, 3'(c));
    rd(8'h00, bf);
    rd(8'h04, cf);
    rd(8'h0c, en);
    chk({5'h0, per_channel_bits_en}, en);
    $display("test descriptor done");
    wr(8'h00, 32'h0);
    rd(8'h00, bf);
    wr(8'h00, 32'h1);
    bf[0] = 1'b0;
    rd(8'h00, bf);
    rd(8'h04, cf);
    wr(8'h04, 32'h20);
    cf[5] = 1'b0;
    rd(8'h04, cf);
    $display("test clear done");
    u_bus_slave_model.fault(5'd3);
    en[3] = 1'b0;
    fork
      wr(8'h00, 32'h8);
      u_bus_slave_model.fault(5'd3);
    join
    bf[3] = 1'b1;
    cf[3] = 1'b1;
    rd(8'h00, bf);
    rd(8'h04, cf);
    chk({5'h0, per_channel_bits_en}, en);
    $display("test race done");
    wr(8'h08, 32'h8);
    irq_is(1'b1);
    wr(8'h08, 32'h0);
    irq_is(1'b0);
    wr(8'h08, 32'h8);
    wr(8'h04, 32'h07ff_ffff);
    irq_is(1'b0);
    rd(8'h04, 32'h0);
    rd(8'h1c, 32'h0);
    $display("test irq done");
    // six faults so far, the last a bus error on channel 3
    rd(8'h14, 32'h0000_8103);
    rd(8'h18, 32'h0000_0006);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    // only lane 0 reaches the enable clear
    lanes = 4'h1;
    wr(8'h10, 32'h0000_0f02);
    lanes = 4'hf;
    en[1] = 1'b0;
    rd(8'h10, en);
    chk({5'h0, per_channel_bits_en}, en);
    $display("test record done");
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    chk({5'h0, per_channel_bits_en}, 32'h0);
    irq_is(1'b0);
    $display("test reset again done");
    end_sim();
  end
endmodule
